// ---- shared/gcsc_pkg.sv ----
/*
 gcsc_pkg: constants for the gauge coil scan control block.
 assumes a plain register port with byte-wide registers and one clock.
*/
package gcsc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int NUM_COILS = 12;
	localparam int COIL_W = 4;
	localparam int NUM_GAUGES = 6;
	// register offsets
	localparam logic [ADDR_W-1:0] OFF_SCAN_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_GAUGE_EN = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_SEQ_STAT = 4'h4;
	// scan_status_control_reg fields
	localparam int BIT_SYNC_FLAG = 6;
	localparam int BIT_SYNC_CLR = 5;
	localparam int BIT_CLKSEL_HI = 3;
	localparam int BIT_CLKSEL_LO = 2;
	localparam int BIT_AUTO = 1;
	localparam int BIT_START = 0;
	// interrupt status bits
	localparam int IRQ_SYNC = 0;
	localparam int IRQ_SCAN_DONE = 1;
	localparam int IRQ_W = 2;
	// coil 11 is index 10 when counted from zero
	localparam logic [COIL_W-1:0] COIL_SYNC_IDX = 4'hA;
	localparam logic [COIL_W-1:0] COIL_LAST_IDX = 4'hB;
	// divider: ratio 512 << sel
	localparam int DIV_W = 12;
	localparam int DIV_BASE_LOG2 = 9;
	localparam logic [DATA_W-1:0] SCAN_CTRL_RST = 8'h00;
	localparam logic [NUM_GAUGES-1:0] GAUGE_EN_RST = 6'h00;
	typedef enum logic [0:0] {
		GCSC_IDLE = 1'b0,
		GCSC_SCAN = 1'b1
	} gcsc_state_e;
endpackage

// ---- core/gcsc_divider.sv ----
/*
 gcsc_divider: one-cycle tick every 512, 1024, 2048 or 4096 clocks.
 assumes the select is stable while the sequencer runs.
*/
`timescale 1ns/100ps
module gcsc_divider (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [1:0] i_sel,
	output logic o_tick
);
	import gcsc_pkg::*;
	logic [gcsc_pkg::DIV_W-1:0] cnt_reg;
	logic [gcsc_pkg::DIV_W-1:0] last;
	// terminal count = (512 << sel) - 1
	assign last = DIV_W'((32'd1 << (DIV_BASE_LOG2 + 32'(i_sel))) - 32'd1);
	always_ff @(posedge i_clk) begin
		if (i_srst || cnt_reg >= last) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
	always_ff @(posedge i_clk) begin
		o_tick <= !i_srst && (cnt_reg == last);
	end
endmodule

// ---- core/gcsc_top.sv ----
/*
 gcsc_top: scan control for a twelve-coil gauge sequencer: mode select,
 manual start, coil pointer, master-to-slave commit, sync flag, interrupt.
 assumes software on a plain one-cycle register port and one 100 MHz clock.
*/
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/100ps
module gcsc_top (
	input wire logic I_CLOCK,
	input wire logic I_SRST,
	input wire logic [gcsc_pkg::ADDR_W-1:0] I_ADDR,
	input wire logic [gcsc_pkg::DATA_W-1:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [gcsc_pkg::DATA_W-1:0] O_RDATA,
	output logic O_IRQ,
	output logic [gcsc_pkg::COIL_W-1:0] O_COIL_IDX,
	output logic O_COIL_STEP,
	output logic O_COIL_DRIVE_EN,
	output logic O_MAG_LOAD,
	output logic O_DIR_LOAD,
	output logic O_COMMIT,
	output logic O_SCAN_ACTIVE
);
	import gcsc_pkg::*;

	logic auto_mode_select_reg;
	logic scan_start_bit_reg;
	logic [1:0] clk_sel_reg;
	logic [NUM_GAUGES-1:0] gauge_enable_reg;
	logic sync_status_flag_reg;
	logic sync_seen_reg;
	logic [IRQ_W-1:0] irq_stat_reg;
	logic [IRQ_W-1:0] irq_mask_reg;
	gcsc_state_e state_reg;
	logic [COIL_W-1:0] coil_reg;
	logic tick;
	logic wr_ctrl;
	logic start_req;
	logic step;
	logic sync_evt;
	logic done_evt;
	logic [DATA_W-1:0] ctrl_view;

	assign wr_ctrl = I_WR && (I_ADDR == OFF_SCAN_CTRL);
	// ignored while set and in auto mode
	assign start_req = wr_ctrl && I_WDATA[BIT_START] && !scan_start_bit_reg
		&& !I_WDATA[BIT_AUTO] && !auto_mode_select_reg;

	gcsc_divider u_div (
		.i_clk(I_CLOCK),
		.i_srst(I_SRST),
		.i_sel(clk_sel_reg),
		.o_tick(tick)
	);

	// a coil step happens on each divider tick while scanning
	assign step = tick && (state_reg == GCSC_SCAN);
	assign sync_evt = step && (coil_reg == COIL_SYNC_IDX - 1'b1);
	assign done_evt = step && (coil_reg == COIL_LAST_IDX)
		&& !auto_mode_select_reg;

	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			auto_mode_select_reg <= SCAN_CTRL_RST[BIT_AUTO];
			clk_sel_reg <= SCAN_CTRL_RST[BIT_CLKSEL_HI:BIT_CLKSEL_LO];
		end else if (wr_ctrl) begin
			auto_mode_select_reg <= I_WDATA[BIT_AUTO];
			clk_sel_reg <= I_WDATA[BIT_CLKSEL_HI:BIT_CLKSEL_LO];
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			gauge_enable_reg <= GAUGE_EN_RST;
		end else if (I_WR && I_ADDR == OFF_GAUGE_EN) begin
			gauge_enable_reg <= I_WDATA[NUM_GAUGES-1:0];
		end
	end

	// start bit: stays 1 until coil 11 begins; a new set wins over the clear
	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			scan_start_bit_reg <= 1'b0;
		end else if (start_req) begin
			scan_start_bit_reg <= 1'b1;
		end else if (sync_evt) begin
			scan_start_bit_reg <= 1'b0;
		end
	end

	// sequencer
	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			state_reg <= GCSC_IDLE;
			coil_reg <= '0;
		end else begin
			case (state_reg)
				GCSC_IDLE: begin
					coil_reg <= '0;
					// auto scans forever; manual waits for the start bit.
					// a start set during the last two coils is held and taken
					// here, otherwise the bit would stay set with no scan
					if (auto_mode_select_reg || start_req
						|| scan_start_bit_reg) begin
						state_reg <= GCSC_SCAN;
					end
				end
				GCSC_SCAN: begin
					if (step) begin
						if (coil_reg == COIL_LAST_IDX) begin
							coil_reg <= '0;
							if (!auto_mode_select_reg) begin
								state_reg <= GCSC_IDLE;
							end
						end else begin
							coil_reg <= coil_reg + 1'b1;
						end
					end
				end
				default: begin
					state_reg <= GCSC_IDLE;
				end
			endcase
		end
	end

	// commit pulses: on manual start for all coils, and at each gauge's
	// first coil. magnitude and direction loads both pulse on every coil step,
	// so a direction-only change also reloads the shared converter value.
	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			O_COMMIT <= 1'b0;
			O_MAG_LOAD <= 1'b0;
			O_DIR_LOAD <= 1'b0;
			O_COIL_STEP <= 1'b0;
		end else begin
			O_COMMIT <= start_req
				|| (step && coil_reg[0]
				&& (coil_reg != COIL_LAST_IDX || auto_mode_select_reg))
				|| (state_reg == GCSC_IDLE && auto_mode_select_reg);
			O_MAG_LOAD <= step;
			O_DIR_LOAD <= step;
			O_COIL_STEP <= step;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			O_COIL_IDX <= '0;
			O_COIL_DRIVE_EN <= 1'b0;
			O_SCAN_ACTIVE <= 1'b0;
		end else begin
			O_COIL_IDX <= coil_reg;
			// slot is spent either way; only the driver follows the enable
			O_COIL_DRIVE_EN <= (state_reg == GCSC_SCAN)
				&& gauge_enable_reg[coil_reg[COIL_W-1:1]];
			O_SCAN_ACTIVE <= (state_reg == GCSC_SCAN);
		end
	end

	// sync flag; set wins over the clear. seen-while-set qualifies clear
	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			sync_status_flag_reg <= 1'b0;
			sync_seen_reg <= 1'b0;
		end else begin
			if (sync_evt) begin
				sync_status_flag_reg <= 1'b1;
			end else if (wr_ctrl && I_WDATA[BIT_SYNC_CLR] && sync_seen_reg) begin
				sync_status_flag_reg <= 1'b0;
			end
			if (I_RD && I_ADDR == OFF_SCAN_CTRL) begin
				sync_seen_reg <= sync_status_flag_reg;
			end else if (!sync_status_flag_reg) begin
				sync_seen_reg <= 1'b0;
			end
		end
	end

	// sticky interrupt status, write one to clear, set wins
	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
		end else begin
			for (int i = 0; i < IRQ_W; i++) begin
				if ((i == IRQ_SYNC && sync_evt)
					|| (i == IRQ_SCAN_DONE && done_evt)) begin
					irq_stat_reg[i] <= 1'b1;
				end else if (I_WR && I_ADDR == OFF_IRQ_STAT && I_WDATA[i]) begin
					irq_stat_reg[i] <= 1'b0;
				end
			end
			if (I_WR && I_ADDR == OFF_IRQ_MASK) begin
				irq_mask_reg <= I_WDATA[IRQ_W-1:0];
			end
		end
	end

	assign O_IRQ = |(irq_stat_reg & irq_mask_reg);

	always_comb begin
		ctrl_view = '0;
		ctrl_view[BIT_SYNC_FLAG] = sync_status_flag_reg;
		ctrl_view[BIT_CLKSEL_HI:BIT_CLKSEL_LO] = clk_sel_reg;
		ctrl_view[BIT_AUTO] = auto_mode_select_reg;
		ctrl_view[BIT_START] = scan_start_bit_reg;
	end

	// unmapped reads return zero
	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			O_RDATA <= '0;
		end else if (I_RD) begin
			case (I_ADDR)
				OFF_SCAN_CTRL: O_RDATA <= ctrl_view;
				OFF_GAUGE_EN: O_RDATA <= DATA_W'(gauge_enable_reg);
				OFF_IRQ_STAT: O_RDATA <= DATA_W'(irq_stat_reg);
				OFF_IRQ_MASK: O_RDATA <= DATA_W'(irq_mask_reg);
				OFF_SEQ_STAT: O_RDATA <= {3'h0, state_reg, coil_reg};
				default: O_RDATA <= '0;
			endcase
		end else begin
			O_RDATA <= '0;
		end
	end

	a_start_self_clr: assert property (
		@(posedge I_CLOCK) disable iff (I_SRST)
		sync_evt && !start_req |=> !scan_start_bit_reg)
		else $error("start not cleared");
	a_sync_sets: assert property (
		@(posedge I_CLOCK) disable iff (I_SRST)
		sync_evt |=> sync_status_flag_reg)
		else $error("sync not set");
	a_auto_no_start: assert property (
		@(posedge I_CLOCK) disable iff (I_SRST)
		auto_mode_select_reg && !scan_start_bit_reg
		|=> !scan_start_bit_reg)
		else $error("auto start");
	a_ignore_reset: assert property (
		@(posedge I_CLOCK) disable iff (I_SRST)
		scan_start_bit_reg && !sync_evt |=> scan_start_bit_reg)
		else $error("start bit dropped");
	a_manual_idle: assert property (
		@(posedge I_CLOCK) disable iff (I_SRST)
		state_reg == GCSC_IDLE && !auto_mode_select_reg && !start_req
		&& !scan_start_bit_reg
		|=> state_reg == GCSC_IDLE)
		else $error("spurious scan");
	a_start_begins: assert property (
		@(posedge I_CLOCK) disable iff (I_SRST)
		start_req && state_reg == GCSC_IDLE |=> state_reg == GCSC_SCAN)
		else $error("scan not started");
	a_commit_start: assert property (
		@(posedge I_CLOCK) disable iff (I_SRST)
		start_req |=> O_COMMIT)
		else $error("no commit");
	a_coil_order: assert property (
		@(posedge I_CLOCK) disable iff (I_SRST)
		step && coil_reg != COIL_LAST_IDX
		|=> coil_reg == $past(coil_reg) + 1'b1)
		else $error("coil order");
endmodule

// ---- testbench/gcsc_cpu_model.sv ----
/*
 gcsc_cpu_model: software side of the register port, one-cycle strobes.
 assumes a rising-edge clock and read data in the cycle after the strobe.
*/
`timescale 1ns/100ps
module gcsc_cpu_model
	import gcsc_pkg::*;
(
	input wire logic i_clk,
	input wire logic [DATA_W-1:0] i_rdata,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	initial begin
		o_addr = 4'h0;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task automatic wr_reg(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		// stale data is not left looking valid
		o_wdata <= ~d;
	endtask
	task automatic rd_reg(input logic [ADDR_W-1:0] a,
		output logic [DATA_W-1:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		@(posedge i_clk);
		d = i_rdata;
	endtask
endmodule

// ---- testbench/gcsc_top_tb.sv ----
/*
 gcsc_top_tb: register-level tests of the scan control block.
 assumes a 100 MHz clock and the software model as bus master.
*/
`timescale 1ns/100ps
module gcsc_top_tb;
	import gcsc_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, d;
	logic wr, rd, irq, step, drv, mag, dir, commit, act;
	logic [COIL_W-1:0] idx;
	int errors = 0;
	int cmp_count = 0;
	int steps = 0;
	int gap = 0;
	int last_gap = 0;
	int tail = 0;
	int loads = 0;
	initial forever #5 clk = ~clk;
	gcsc_cpu_model u_cpu (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
		.o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	gcsc_top u_dut (.I_CLOCK(clk), .I_SRST(srst), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
		.O_IRQ(irq), .O_COIL_IDX(idx), .O_COIL_STEP(step),
		.O_COIL_DRIVE_EN(drv), .O_MAG_LOAD(mag), .O_DIR_LOAD(dir),
		.O_COMMIT(commit), .O_SCAN_ACTIVE(act));
	// interval and tail counters measured off the design's own pulses
	always @(posedge clk) begin
		gap <= gap + 1;
		if (step === 1'b1) begin
			steps <= steps + 1;
			last_gap <= gap;
			gap <= 1;
		end
		if (act === 1'b1 && idx >= COIL_SYNC_IDX)
			tail <= tail + 1;
		if (mag === 1'b1 && dir === 1'b1)
			loads <= loads + 1;
	end
	task automatic chk(input string n, input logic [7:0] got,
		input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wait_coil(input logic [COIL_W-1:0] v);
		int i;
		for (i = 0; i < 15000 && idx !== v; i++)
			@(posedge clk);
		if (i == 15000)
			errors++;
	endtask
	task automatic final_report;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#800000;
		errors++;
		final_report();
	end
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		u_cpu.rd_reg(OFF_SCAN_CTRL, d);
		chk("ctrl_rst", d, SCAN_CTRL_RST);
		u_cpu.rd_reg(4'hF, d);
		chk("unmapped", d, 8'h00);
		u_cpu.wr_reg(OFF_GAUGE_EN, 8'h01);
		u_cpu.wr_reg(OFF_SCAN_CTRL, 8'h01);
		// outputs launched at the strobe edge are settled by the falling edge
		@(negedge clk);
		chk("commit", {7'h0, commit}, 8'h01);
		@(negedge clk);
		chk("active", {7'h0, act}, 8'h01);
		chk("drive_g0", {7'h0, drv}, 8'h01);
		u_cpu.wr_reg(OFF_SCAN_CTRL, 8'h01);
		u_cpu.rd_reg(OFF_SCAN_CTRL, d);
		chk("start_poll", d, 8'h01);
		wait_coil(COIL_SYNC_IDX);
		repeat (3) @(posedge clk);
		chk("drive_g5", {7'h0, drv}, 8'h00);
		u_cpu.rd_reg(OFF_SCAN_CTRL, d);
		chk("self_clear", d, 8'h40);
		chk("irq_masked", {7'h0, irq}, 8'h00);
		u_cpu.wr_reg(OFF_IRQ_MASK, 8'h01);
		@(posedge clk);
		chk("irq_on", {7'h0, irq}, 8'h01);
		u_cpu.wr_reg(OFF_IRQ_STAT, 8'h01);
		@(posedge clk);
		chk("irq_w1c", {7'h0, irq}, 8'h00);
		u_cpu.wr_reg(OFF_SCAN_CTRL, 8'h20);
		u_cpu.rd_reg(OFF_SCAN_CTRL, d);
		chk("sync_clr", d, 8'h00);
		repeat (1500) @(posedge clk);
		// a refused second start leaves the count at one scan of 12 steps
		chk("steps", 8'(steps), 8'd12);
		chk("loads", 8'(loads), 8'd12);
		chk("tail", 8'(tail >= 1022 && tail <= 1026), 8'h01);
		chk("gap512", 8'(last_gap == 512), 8'h01);
		chk("idle", {7'h0, act}, 8'h00);
		u_cpu.rd_reg(OFF_IRQ_STAT, d);
		chk("done_irq", d, 8'h02);
		u_cpu.wr_reg(OFF_SCAN_CTRL, 8'h06);
		repeat (1100) @(posedge clk);
		chk("auto_run", {7'h0, act}, 8'h01);
		u_cpu.wr_reg(OFF_SCAN_CTRL, 8'h07);
		wait_coil(COIL_SYNC_IDX);
		wait_coil(4'h0);
		wait_coil(4'h3);
		chk("auto_wrap", {7'h0, act}, 8'h01);
		chk("gap1024", 8'(last_gap == 1024), 8'h01);
		u_cpu.rd_reg(OFF_SCAN_CTRL, d);
		chk("auto_ctrl", d, 8'h46);
		final_report();
	end
endmodule
